// ==== pcwg_pkg.sv ====
// Package for the PLL hold window generator.
// Assumes a single line-domain clock and a plain register port.
package pcwg_pkg;
  localparam logic [7:0] PCWG_ADDR_CFG = 8'h0f;
  localparam logic [7:0] PCWG_ADDR_EARLY = 8'h12;
  localparam logic [7:0] PCWG_ADDR_LATE = 8'h13;
  localparam logic [7:0] PCWG_ADDR_STATUS = 8'h14;
  localparam int PCWG_CFG_EXT_BIT = 5;
  localparam int PCWG_CFG_VS_POL_BIT = 0;
  localparam int PCWG_STAT_POL_BIT = 0;
  localparam logic [7:0] PCWG_CFG_RST = 8'h00;
  localparam logic [7:0] PCWG_EARLY_RST = 8'h00;
  localparam logic [7:0] PCWG_LATE_RST = 8'h00;
  localparam int PCWG_LINE_W = 11;
  localparam int PCWG_DUTY_W = 16;
  localparam logic [PCWG_DUTY_W-1:0] PCWG_DUTY_MID = 16'h8000;
endpackage

// ==== pcwg_sync_if.sv ====
// Interface carrying pulses and line counts between the hold window modules.
// Assumes all members live in the single clock domain.
`timescale 1ns/1ps
interface pcwg_sync_if;
  logic lineTick;
  logic vsActive;
  logic vsStart;
  logic vsEnd;
  logic frameValid;
  logic [10:0] frameLines;
  logic [10:0] lineCount;
  modport meas (input lineTick, input vsActive, input vsStart, input vsEnd,
    output frameValid, output frameLines, output lineCount);
  modport use_side (input lineTick, input vsActive, input vsStart, input vsEnd,
    input frameValid, input frameLines, input lineCount);
endinterface

// ==== pcwg_polarity_det.sv ====
// Duty-cycle polarity detector for the external hold input.
// Assumes the input is synchronous to clock.
`timescale 1ns/1ps
module pcwg_polarity_det
  import pcwg_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rstSyncN,
  // Sampled signal and result.
  input wire logic sigIn,
  output logic polPositive
);
  logic [PCWG_DUTY_W-1:0] duty_q, duty_d;
  logic pol_q, pol_d;

  // A saturating up/down counter leans toward the level seen most often.
  always_comb begin
    duty_d = duty_q;
    if (sigIn && duty_q != '1) begin
      duty_d = duty_q + 1'b1;
    end else if (!sigIn && duty_q != '0) begin
      duty_d = duty_q - 1'b1;
    end
    pol_d = pol_q;
    if (duty_q == '0) begin
      pol_d = 1'b1;
    end else if (duty_q == '1) begin
      pol_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      duty_q <= PCWG_DUTY_MID;
      pol_q <= 1'b1;
    end else begin
      duty_q <= duty_d;
      pol_q <= pol_d;
    end
  end

  assign polPositive = pol_q;
endmodule

// ==== pcwg_line_meas.sv ====
// Line counter measuring frame length in horizontal sync pulses.
// Assumes one lineTick pulse per line and one vsStart pulse per frame.
`timescale 1ns/1ps
module pcwg_line_meas
  import pcwg_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rstSyncN,
  // Sync events and measurements.
  pcwg_sync_if.meas sb
);
  logic [PCWG_LINE_W-1:0] cnt_q, cnt_d;
  logic [PCWG_LINE_W-1:0] len_q, len_d;
  logic valid_q, valid_d;
  logic seen_q, seen_d;

  always_comb begin
    cnt_d = cnt_q;
    len_d = len_q;
    valid_d = valid_q;
    seen_d = seen_q;
    if (sb.vsStart) begin
      // The count wraps beyond 2048 lines; such frames are not supported.
      len_d = cnt_q;
      valid_d = seen_q;
      seen_d = 1'b1;
      cnt_d = '0;
    end else if (sb.lineTick) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cnt_q <= '0;
      len_q <= '0;
      valid_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      len_q <= len_d;
      valid_q <= valid_d;
      seen_q <= seen_d;
    end
  end

  assign sb.frameValid = valid_q;
  assign sb.frameLines = len_q;
  assign sb.lineCount = cnt_q;
endmodule

// ==== pcwg_coast_gen.sv ====
// Top of the PLL hold window generator: registers, sync edges and hold output.
// Assumes hsync, vsync and the external hold pin are synchronous to clock.
`timescale 1ns/1ps
module pcwg_coast_gen
  import pcwg_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Video sync inputs and external hold input.
  input wire logic hsyncIn,
  input wire logic vsyncIn,
  input wire logic holdIn,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // PLL control.
  output logic pllHold,
  output logic pllRefEn
);
  logic rstMeta_q, rstSyncN;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] early_q, early_d;
  logic [7:0] late_q, late_d;
  logic [7:0] rdata_q, rdata_d;
  logic hs_q, vsn_q;
  logic [7:0] post_q, post_d;
  logic earlyWin_q, earlyWin_d;
  logic hold_q, hold_d;
  logic vsNorm, holdPos;
  logic [PCWG_LINE_W:0] predStart;
  logic [PCWG_LINE_W-1:0] startLine;

  pcwg_sync_if sb ();

  // The release is synchronised so no flip-flop leaves reset on a partial edge.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSyncN <= rstMeta_q;
    end
  end

  pcwg_polarity_det uPol (
    .clock(clock),
    .rstSyncN(rstSyncN),
    .sigIn(holdIn),
    .polPositive(holdPos)
  );

  pcwg_line_meas uMeas (
    .clock(clock),
    .rstSyncN(rstSyncN),
    .sb(sb)
  );

  // Vertical sync polarity is set by software; bit 0 high means active low.
  assign vsNorm = vsyncIn ^ cfg_q[PCWG_CFG_VS_POL_BIT];
  assign sb.lineTick = hsyncIn & ~hs_q;
  assign sb.vsActive = vsNorm;
  assign sb.vsStart = vsNorm & ~vsn_q;
  assign sb.vsEnd = ~vsNorm & vsn_q;

  // Predicted start line is frame length less the early count, floored at zero.
  assign predStart = {1'b0, sb.frameLines} - {4'h0, early_q};
  assign startLine = predStart[PCWG_LINE_W] ? '0 : predStart[PCWG_LINE_W-1:0];

  always_comb begin
    earlyWin_d = earlyWin_q;
    post_d = post_q;
    if (sb.vsStart) begin
      earlyWin_d = 1'b0;
    end else if (sb.frameValid && early_q != 8'h00 && sb.lineCount == startLine) begin
      earlyWin_d = 1'b1;
    end
    if (sb.vsEnd) begin
      post_d = late_q;
    end else if (sb.lineTick && post_q != 8'h00 && !vsNorm) begin
      post_d = post_q - 8'h01;
    end
    if (cfg_q[PCWG_CFG_EXT_BIT]) begin
      hold_d = holdPos ? holdIn : ~holdIn;
    end else begin
      // The next late count is used so hold does not drop for a cycle as vertical sync ends.
      hold_d = vsNorm | earlyWin_q | (post_d != 8'h00);
    end
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      hs_q <= 1'b0;
      vsn_q <= 1'b0;
      earlyWin_q <= 1'b0;
      post_q <= 8'h00;
      hold_q <= 1'b0;
    end else begin
      hs_q <= hsyncIn;
      vsn_q <= vsNorm;
      earlyWin_q <= earlyWin_d;
      post_q <= post_d;
      hold_q <= hold_d;
    end
  end

  assign pllHold = hold_q;
  assign pllRefEn = ~hold_q;

  // Register port; unmapped reads return zero.
  always_comb begin
    cfg_d = cfg_q;
    early_d = early_q;
    late_d = late_q;
    rdata_d = 8'h00;
    if (regWrite) begin
      unique case (regAddr)
        PCWG_ADDR_CFG: begin
          cfg_d = regWdata;
        end
        PCWG_ADDR_EARLY: begin
          early_d = regWdata;
        end
        PCWG_ADDR_LATE: begin
          late_d = regWdata;
        end
        default: begin
        end
      endcase
    end
    if (regRead) begin
      unique case (regAddr)
        PCWG_ADDR_CFG: begin
          rdata_d = cfg_q;
        end
        PCWG_ADDR_EARLY: begin
          rdata_d = early_q;
        end
        PCWG_ADDR_LATE: begin
          rdata_d = late_q;
        end
        PCWG_ADDR_STATUS: begin
          rdata_d[PCWG_STAT_POL_BIT] = holdPos;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      cfg_q <= PCWG_CFG_RST;
      early_q <= PCWG_EARLY_RST;
      late_q <= PCWG_LATE_RST;
      rdata_q <= 8'h00;
    end else begin
      cfg_q <= cfg_d;
      early_q <= early_d;
      late_q <= late_d;
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;
endmodule

// ==== pcwg_asserts.sv ====
// Checker on the hold generator ports.
// Assumes it is bound into pcwg_coast_gen.
`timescale 1ns/1ps
module pcwg_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic vsyncIn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic pllHold,
  input wire logic pllRefEn
);
  logic [7:0] cfg_q;
  logic [7:0] late_q;
  logic [2:0] up_q;
  // Outputs stay quiet two edges after release, so hold checks wait three.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= 8'h00;
      late_q <= 8'h00;
      up_q <= 3'h0;
    end else begin
      up_q <= {up_q[1:0], 1'b1};
      if (regWrite && regAddr == 8'h0f) cfg_q <= regWdata;
      if (regWrite && regAddr == 8'h13) late_q <= regWdata;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ref_inv_a: assert property (pllRefEn == !pllHold)
    else $error("Reference enable wrong.");
  rd_idle_a: assert property (!regRead |=> regRdata == 8'h00)
    else $error("Read data not idle.");
  stat_bits_a: assert property (regRead && regAddr == 8'h14 |=> regRdata[7:1] == 7'h00)
    else $error("Status spare bits set.");
  unmapped_a: assert property (regRead && regAddr == 8'h15 |=> regRdata == 8'h00)
    else $error("Unmapped read not zero.");
  early_rd_a: assert property (regWrite && regAddr == 8'h12 ##2 regRead && regAddr == 8'h12
    |=> regRdata == $past(regWdata, 3))
    else $error("Early count lost.");
  late_rd_a: assert property (regWrite && regAddr == 8'h13 ##2 regRead && regAddr == 8'h13
    |=> regRdata == $past(regWdata, 3))
    else $error("Late count lost.");
  vs_hold_a: assert property (up_q[2] && cfg_q == 8'h00 && vsyncIn |=> pllHold)
    else $error("Hold missing in sync.");
  late_zero_a: assert property (up_q[2] && cfg_q == 8'h00 && late_q == 8'h00 && $fell(vsyncIn)
    |=> !pllHold)
    else $error("Hold held without late.");
  late_keep_a: assert property (up_q[2] && cfg_q == 8'h00 && late_q != 8'h00 && $fell(vsyncIn)
    |=> pllHold)
    else $error("Hold dropped at sync end.");
endmodule
bind pcwg_coast_gen pcwg_asserts chk (.clock, .rst_n, .vsyncIn, .regAddr, .regWdata,
  .regWrite, .regRead, .regRdata, .pllHold, .pllRefEn);

// ==== pcwg_video_src.sv ====
// Video source model making line and frame sync.
// Assumes a free clock; both syncs stay low while disabled.
`timescale 1ns/1ps
module pcwg_video_src (
  input wire logic clock,
  input wire logic en,
  output logic hsync,
  output logic vsync,
  output logic [10:0] line,
  output logic [2:0] pix
);
  // Twenty lines of eight clocks, vertical sync on the first two.
  always @(posedge clock) begin
    pix <= en ? pix + 3'h1 : 3'h0;
    if (!en) line <= 11'h000;
    else if (pix == 3'h7) line <= (line == 11'h013) ? 11'h000 : line + 11'h001;
  end
  assign hsync = en && pix < 3'h2;
  assign vsync = en && line < 11'h002;
endmodule

// ==== tb_top.sv ====
// Testbench for the hold window generator.
// Assumes the design, checker and video source are compiled first.
`timescale 1ns/1ps
module tb_top;
  import pcwg_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic holdIn = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic srcEn = 1'b0;
  logic hsyncIn, vsyncIn, pllHold, pllRefEn;
  logic [7:0] regRdata;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #4 clock = ~clock;
  pcwg_video_src src (.clock, .en(srcEn), .hsync(hsyncIn), .vsync(vsyncIn), .line(), .pix());
  pcwg_coast_gen dut (.clock, .rst_n, .hsyncIn, .vsyncIn, .holdIn, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .pllHold, .pllRefEn);
  task automatic results();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      results();
    end
  end
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  // Waits for a line and pixel of the source, then judges the hold level.
  task automatic at(input logic [10:0] l, input logic [2:0] p, input logic e);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (!(src.line == l && src.pix == p) && n < 400);
    chk({7'h00, pllHold}, {7'h00, e});
  endtask
  task automatic t_regs();
    rd(PCWG_ADDR_EARLY, PCWG_EARLY_RST);
    rd(PCWG_ADDR_LATE, PCWG_LATE_RST);
    rd(PCWG_ADDR_STATUS, 8'h01);
    rd(8'h15, 8'h00);
    wr(PCWG_ADDR_STATUS, 8'h00);
    rd(PCWG_ADDR_STATUS, 8'h01);
    wr(PCWG_ADDR_EARLY, 8'hff);
    rd(PCWG_ADDR_EARLY, 8'hff);
    wr(PCWG_ADDR_LATE, 8'hff);
    rd(PCWG_ADDR_LATE, 8'hff);
  endtask
  task automatic t_late();
    wr(PCWG_ADDR_EARLY, 8'h00);
    wr(PCWG_ADDR_LATE, 8'h03);
    srcEn <= 1'b1;
    at(11'h001, 3'h4, 1'b1);
    at(11'h003, 3'h4, 1'b1);
    at(11'h006, 3'h4, 1'b0);
    wr(PCWG_ADDR_LATE, 8'h00);
    at(11'h002, 3'h4, 1'b0);
  endtask
  task automatic t_early();
    wr(PCWG_ADDR_EARLY, 8'h02);
    at(11'h010, 3'h4, 1'b0);
    at(11'h013, 3'h4, 1'b1);
    wr(PCWG_ADDR_EARLY, 8'h00);
    at(11'h013, 3'h4, 1'b0);
    srcEn <= 1'b0;
  endtask
  task automatic t_pol();
    wr(PCWG_ADDR_CFG, 8'h01);
    repeat (2) @(posedge clock);
    #1 chk({7'h00, pllHold}, 8'h01);
    rd(PCWG_ADDR_CFG, 8'h01);
    wr(PCWG_ADDR_CFG, 8'h20);
    holdIn <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk({7'h00, pllHold}, 8'h01);
    repeat (34000) @(posedge clock);
    rd(PCWG_ADDR_STATUS, 8'h00);
    chk({7'h00, pllHold}, 8'h00);
    @(posedge clock);
    holdIn <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk({7'h00, pllHold}, 8'h01);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs();
    t_late();
    t_early();
    t_pol();
    results();
  end
endmodule
